// ---- design/ssm_pkg.sv ----
// package for the segment serial master: register map, layouts, states
// assumes an apb slave port at 100 mhz and a serial slave on the far side
// How it works
// [R1] chip select framed around every word
// [R2] transmit memory and receive queue, 16k words
// [R3] words fetched and stored in sequence
// [R4] serial clock period in 20 ns steps
// [R5] serial clock polarity may be inverted
// [R6] word width from 1 to 16 bits
// [R7] msb first, transmit word left aligned
// [R8] software reads received words unshifted; the queue already holds them right aligned in the low width bits
// [R9] three modes: word, segment, cyclic
// [R10] word mode sends one word then idles
// [R11] segment word interval in 5 ns steps
// [R12] segment mode appends words written while running
// [R13] stop-on-empty halts after last word
// [R14] otherwise last word is resent each interval
// [R15] cyclic mode restarts from first word
// [R16] software must not append in cyclic mode
// [R17] miso sampled every word, word stored
// [R18] receive queue is fifo, readable at once
// [R19] reading the queue pops the word
// [R20] timing base from fast internal clock
// [R21] all control through registers on bus
// [R22] chip select idle one period between words
// [R23] full queue drops word, sets sticky overflow
package ssm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned SCLK_STEP_NS = 20;
  localparam int unsigned SCLK_STEP_CYC = (SCLK_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RATE_STEP_NS = 5;
  localparam int unsigned MEM_DEPTH = 16384;
  // register byte offsets
  localparam logic [11:0] SSM_CTRL_OFS = 12'h000;
  localparam logic [11:0] SSM_DIV_OFS = 12'h004;
  localparam logic [11:0] SSM_RATE_OFS = 12'h008;
  localparam logic [11:0] SSM_TXDATA_OFS = 12'h00c;
  localparam logic [11:0] SSM_RXDATA_OFS = 12'h010;
  localparam logic [11:0] SSM_STAT_OFS = 12'h014;
  localparam logic [11:0] SSM_SEGLEN_OFS = 12'h018;
  localparam logic [11:0] SSM_CMD_OFS = 12'h01c;
  // ctrl fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_CPOL_BIT = 2;
  localparam int unsigned CTRL_STOPE_BIT = 3;
  localparam int unsigned CTRL_WIDTH_LSB = 4;
  // cmd fields
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_STOP_BIT = 1;
  localparam int unsigned CMD_CLR_BIT = 2;
  localparam int unsigned CMD_OVFCLR_BIT = 3;
  // reset values
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [22:0] RATE_RST = 23'h000fff;
  localparam logic [3:0] WIDTH_RST = 4'hf;

  typedef enum logic [1:0] {
    SSM_MODE_WORD = 2'h0,
    SSM_MODE_SEG = 2'h1,
    SSM_MODE_CYC = 2'h2
  } ssm_mode_t;

  // gray coded along idle -> load -> shift -> gap
  typedef enum logic [1:0] {
    SSM_ST_IDLE = 2'b00,
    SSM_ST_LOAD = 2'b01,
    SSM_ST_SHIFT = 2'b11,
    SSM_ST_GAP = 2'b10
  } ssm_state_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
  } ssm_serial_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } ssm_apb_req_t;
endpackage

// ---- design/ssm_top.sv ----
// segment serial master: apb registers, transmit memory, receive queue, shifter
// assumes miso arrives asynchronously and software keeps to the register map
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module ssm_top #(
  parameter int unsigned DEPTH = ssm_pkg::MEM_DEPTH,
  parameter int unsigned AW = 14
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // apb slave
  input wire ssm_pkg::ssm_apb_req_t apb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // serial link
  input wire logic miso_in,
  output ssm_pkg::ssm_serial_t ser_out,
  // status
  output logic busy_out
);
  import ssm_pkg::*;

  initial begin
    if (DEPTH != (1 << AW) || AW < 2 || AW > 16) begin
      $error("ssm_top: DEPTH must equal 2**AW");
    end
  end

  // ----------------------------------------------------------------
  // miso synchroniser
  // ----------------------------------------------------------------
  logic miso_s1_r;
  logic miso_s2_r;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else begin
      miso_s1_r <= miso_in;
      miso_s2_r <= miso_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // registers and bus decode
  // ----------------------------------------------------------------
  ssm_mode_t mode_r;
  logic cpol_r;
  logic stop_empty_r;
  logic [3:0] width_r;
  logic [15:0] div_r;
  logic [22:0] rate_r;
  logic ovf_r;
  logic [AW:0] wr_ptr_r;
  logic [AW:0] seg_len_r;

  wire acc = apb_in.psel && apb_in.penable;
  wire wr = acc && apb_in.pwrite;
  wire rd = acc && !apb_in.pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  wire mapped = hit(apb_in.paddr, SSM_CTRL_OFS) || hit(apb_in.paddr, SSM_DIV_OFS) ||
    hit(apb_in.paddr, SSM_RATE_OFS) || hit(apb_in.paddr, SSM_TXDATA_OFS) ||
    hit(apb_in.paddr, SSM_RXDATA_OFS) || hit(apb_in.paddr, SSM_STAT_OFS) ||
    hit(apb_in.paddr, SSM_SEGLEN_OFS) || hit(apb_in.paddr, SSM_CMD_OFS);
  wire cmd_wr = wr && hit(apb_in.paddr, SSM_CMD_OFS);
  wire start_cmd = cmd_wr && apb_in.pwdata[CMD_START_BIT];
  wire stop_cmd = cmd_wr && apb_in.pwdata[CMD_STOP_BIT];
  wire clr_cmd = cmd_wr && apb_in.pwdata[CMD_CLR_BIT];
  // [R21] control over bus
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mode_r <= SSM_MODE_WORD;
      cpol_r <= 1'b0;
      stop_empty_r <= 1'b0;
      width_r <= WIDTH_RST;
      div_r <= DIV_RST;
      rate_r <= RATE_RST;
    end else if (wr && !busy_out) begin
      if (hit(apb_in.paddr, SSM_CTRL_OFS)) begin
        mode_r <= ssm_mode_t'(apb_in.pwdata[CTRL_MODE_LSB +: 2]);
        cpol_r <= apb_in.pwdata[CTRL_CPOL_BIT];
        stop_empty_r <= apb_in.pwdata[CTRL_STOPE_BIT];
        width_r <= apb_in.pwdata[CTRL_WIDTH_LSB +: 4];
      end
      if (hit(apb_in.paddr, SSM_DIV_OFS)) begin
        div_r <= apb_in.pwdata[15:0];
      end
      if (hit(apb_in.paddr, SSM_RATE_OFS)) begin
        rate_r <= apb_in.pwdata[22:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit memory, written in order
  // ----------------------------------------------------------------
  // [R2] transmit storage
  logic [15:0] tx_mem [DEPTH];
  wire tx_push = wr && hit(apb_in.paddr, SSM_TXDATA_OFS) && !wr_ptr_r[AW];
  // [R3] sequential load
  always_ff @(posedge clk_in) begin
    if (tx_push) begin
      tx_mem[wr_ptr_r[AW-1:0]] <= apb_in.pwdata[15:0];
    end
  end
  // [R12] appended words lengthen segment
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || clr_cmd) begin
      wr_ptr_r <= '0;
    end else if (tx_push) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // receive queue
  // ----------------------------------------------------------------
  logic [15:0] rx_mem [DEPTH];
  logic [AW:0] rx_wp_r;
  logic [AW:0] rx_rp_r;
  wire [AW:0] rx_cnt = rx_wp_r - rx_rp_r;
  wire rx_full = rx_cnt[AW];
  wire rx_empty = (rx_cnt == '0);
  logic word_done;
  logic [15:0] rx_word;
  wire rx_push = word_done && !rx_full;
  // [R19] read pops
  wire rx_pop = rd && hit(apb_in.paddr, SSM_RXDATA_OFS) && !rx_empty;
  // [R17] store received word
  always_ff @(posedge clk_in) begin
    if (rx_push) begin
      rx_mem[rx_wp_r[AW-1:0]] <= rx_word;
    end
  end
  // [R18] fifo pointers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || clr_cmd) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
    end else begin
      if (rx_push) begin
        rx_wp_r <= rx_wp_r + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_r <= rx_rp_r + 1'b1;
      end
    end
  end
  // [R23] sticky overflow, set wins
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ovf_r <= 1'b0;
    end else if (word_done && rx_full) begin
      ovf_r <= 1'b1;
    end else if (cmd_wr && apb_in.pwdata[CMD_OVFCLR_BIT]) begin
      ovf_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data and ready
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= apb_in.psel && !apb_in.penable;
      pslverr_out <= apb_in.psel && !apb_in.penable && !mapped;
      prdata_out <= 32'h0000_0000;
      if (apb_in.psel && !apb_in.penable && !apb_in.pwrite) begin
        case (apb_in.paddr)
          SSM_CTRL_OFS: prdata_out <= {24'h0, width_r, stop_empty_r, cpol_r, mode_r};
          SSM_DIV_OFS: prdata_out <= {16'h0, div_r};
          SSM_RATE_OFS: prdata_out <= {9'h0, rate_r};
          SSM_RXDATA_OFS: prdata_out <= {16'h0, rx_mem[rx_rp_r[AW-1:0]]};
          SSM_STAT_OFS: prdata_out <= {28'h0, ovf_r, rx_full, rx_empty, busy_out};
          SSM_SEGLEN_OFS: prdata_out <= 32'(wr_ptr_r);
          default: prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // word interval timer
  // ----------------------------------------------------------------
  // [R11] interval in 5 ns units, counted at clk rate
  logic [23:0] rate_cnt_r;
  wire rate_tick = (rate_cnt_r == '0);
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !busy_out) begin
      rate_cnt_r <= '0;
    end else if (rate_tick) begin
      rate_cnt_r <= 24'((rate_r * RATE_STEP_NS) / CLK_NS);
    end else begin
      rate_cnt_r <= rate_cnt_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // serial clock half period enable
  // ----------------------------------------------------------------
  // [R4] half period = (div+1)*20ns/2 = (div+1) clk cycles
  logic [16:0] half_cnt_r;
  ssm_state_t st_r;
  wire half_tick = (half_cnt_r == '0);
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || st_r == SSM_ST_IDLE || st_r == SSM_ST_LOAD) begin
      half_cnt_r <= 17'(div_r);
    end else if (half_tick) begin
      half_cnt_r <= 17'(div_r) * 17'(SCLK_STEP_CYC / 2);
    end else begin
      half_cnt_r <= half_cnt_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  logic [AW:0] rd_ptr_r;
  logic [15:0] sh_tx_r;
  logic [15:0] sh_rx_r;
  logic [4:0] bit_cnt_r;
  logic phase_r;
  logic pending_r;
  logic gap_done_r;
  assign rx_word = sh_rx_r;
  assign word_done = (st_r == SSM_ST_SHIFT) && half_tick && phase_r && (bit_cnt_r == 5'h01);

  // [R14] next word index; holds on last word when nothing new
  wire have_next = (rd_ptr_r + 1'b1) < wr_ptr_r;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pending_r <= 1'b0;
    end else if (start_cmd || (busy_out && rate_tick && st_r != SSM_ST_IDLE)) begin
      pending_r <= 1'b1;
    end else if (st_r == SSM_ST_LOAD) begin
      pending_r <= 1'b0;
    end
  end

  // [R9] mode dependent sequencing
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_r <= SSM_ST_IDLE;
      busy_out <= 1'b0;
      rd_ptr_r <= '0;
      sh_tx_r <= 16'h0000;
      sh_rx_r <= 16'h0000;
      bit_cnt_r <= 5'h00;
      phase_r <= 1'b0;
      gap_done_r <= 1'b0;
      ser_out <= '{sclk: 1'b0, mosi: 1'b0, cs_n: 1'b1};
    end else if (stop_cmd) begin
      st_r <= SSM_ST_IDLE;
      busy_out <= 1'b0;
      ser_out <= '{sclk: cpol_r, mosi: 1'b0, cs_n: 1'b1};
    end else begin
      case (st_r)
        SSM_ST_IDLE: begin
          // [R5] idle level follows polarity
          ser_out.sclk <= cpol_r;
          ser_out.cs_n <= 1'b1;
          if (start_cmd && wr_ptr_r != '0) begin
            busy_out <= 1'b1;
            rd_ptr_r <= '0;
            st_r <= SSM_ST_LOAD;
          end
        end
        SSM_ST_LOAD: begin
          // [R7] msb first from left aligned word
          sh_tx_r <= tx_mem[rd_ptr_r[AW-1:0]];
          ser_out.mosi <= tx_mem[rd_ptr_r[AW-1:0]][15];
          // [R1] frame word with chip select
          ser_out.cs_n <= 1'b0;
          // [R6] width field holds width-1
          bit_cnt_r <= 5'(width_r) + 5'h01;
          phase_r <= 1'b0;
          sh_rx_r <= 16'h0000;
          st_r <= SSM_ST_SHIFT;
        end
        SSM_ST_SHIFT: begin
          if (half_tick) begin
            phase_r <= !phase_r;
            ser_out.sclk <= !ser_out.sclk;
            if (!phase_r) begin
              // [R17] sample on leading edge
              sh_rx_r <= {sh_rx_r[14:0], miso_s2_r};
            end else begin
              sh_tx_r <= {sh_tx_r[14:0], 1'b0};
              ser_out.mosi <= sh_tx_r[14];
              bit_cnt_r <= bit_cnt_r - 1'b1;
              if (bit_cnt_r == 5'h01) begin
                // [R22] release select, idle clock
                ser_out.cs_n <= 1'b1;
                ser_out.sclk <= cpol_r;
                gap_done_r <= 1'b0;
                st_r <= SSM_ST_GAP;
              end
            end
          end
        end
        SSM_ST_GAP: begin
          // [R8] receive word right aligned in the low width bits
          if (word_done) begin
            sh_rx_r <= sh_rx_r;
          end
          if (half_tick) begin
            gap_done_r <= 1'b1;
          end
          if (gap_done_r && half_tick) begin
            case (mode_r)
              // [R10] single word then idle
              SSM_MODE_WORD: begin
                st_r <= SSM_ST_IDLE;
                busy_out <= 1'b0;
              end
              SSM_MODE_SEG: begin
                if (have_next) begin
                  if (pending_r) begin
                    rd_ptr_r <= rd_ptr_r + 1'b1;
                    st_r <= SSM_ST_LOAD;
                  end
                end else if (stop_empty_r) begin
                  // [R13] halt after last word
                  st_r <= SSM_ST_IDLE;
                  busy_out <= 1'b0;
                end else if (pending_r) begin
                  // [R14] resend last word
                  st_r <= SSM_ST_LOAD;
                end
              end
              SSM_MODE_CYC: begin
                if (pending_r) begin
                  // [R15] wrap to first word
                  rd_ptr_r <= have_next ? rd_ptr_r + 1'b1 : '0;
                  st_r <= SSM_ST_LOAD;
                end
              end
              default: begin
                st_r <= SSM_ST_IDLE;
                busy_out <= 1'b0;
              end
            endcase
          end
        end
        default: st_r <= SSM_ST_IDLE;
      endcase
    end
  end
endmodule

// ---- tb/ssm_slave_model.sv ----
// serial slave model: shifts a word out on miso, captures mosi
// assumes the master samples on the leading sclk edge and shifts on the trailing one
`timescale 1ns/1ps
module ssm_slave_model (
  // serial side
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic cs_n_in,
  output logic miso_out,
  // bench side
  input wire logic cpol_in,
  input wire logic [15:0] tx_word_in,
  output logic [15:0] rx_word_out,
  output logic [4:0] rx_bits_out,
  output logic done_out
);
  logic [15:0] sh;
  initial begin
    miso_out = 1'b0;
    done_out = 1'b0;
    rx_word_out = 16'h0000;
    rx_bits_out = 5'h00;
    sh = 16'h0000;
  end
  always @(negedge cs_n_in) begin
    sh = tx_word_in;
    rx_word_out = 16'h0000;
    rx_bits_out = 5'h00;
    miso_out = sh[15];
  end
  always @(sclk_in) begin
    if (!cs_n_in && sclk_in !== cpol_in) begin
      rx_word_out = {rx_word_out[14:0], mosi_in};
      rx_bits_out = rx_bits_out + 5'h01;
    end else if (!cs_n_in) begin
      sh = {sh[14:0], 1'b0};
      miso_out = sh[15];
    end
  end
  // released line shows the inverse of the last bit
  always @(posedge cs_n_in) begin
    miso_out = ~miso_out;
    done_out = ~done_out;
  end
endmodule

// ---- tb/ssm_top_properties.sv ----
// checker for the segment serial master, sees the top ports only
// assumes one clock domain and a synchronous active low reset
`timescale 1ns/1ps
module ssm_properties
  import ssm_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire ssm_pkg::ssm_apb_req_t apb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic miso_in,
  input wire ssm_pkg::ssm_serial_t ser_out,
  input wire logic busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic cpol_r;
  // tracks the programmed idle level of sclk
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cpol_r <= 1'b0;
    end else if (apb_in.psel && apb_in.penable && apb_in.pwrite && pready_out && !busy_out
        && apb_in.paddr == SSM_CTRL_OFS) begin
      cpol_r <= apb_in.pwdata[CTRL_CPOL_BIT];
    end
  end
  a_ready_next: assert property (
    apb_in.psel && !apb_in.penable |=> pready_out) else $error("no ready after setup");
  a_ready_pulse: assert property (
    pready_out |=> !pready_out) else $error("ready held too long");
  a_unmapped_err: assert property (
    apb_in.psel && !apb_in.penable && apb_in.paddr[1:0] == 2'h0
    |=> pslverr_out == ($past(apb_in.paddr) > 12'h01c)) else $error("wrong slave error");
  a_frame_busy: assert property (
    $fell(ser_out.cs_n) |-> busy_out) else $error("select without busy");
  a_frame_min: assert property (
    $fell(ser_out.cs_n) |-> !ser_out.cs_n [*2]) else $error("frame too short");
  a_gap_min: assert property (
    $rose(ser_out.cs_n) |-> ser_out.cs_n [*2]) else $error("gap too short");
  a_idle_deselect: assert property (
    !busy_out |-> ser_out.cs_n) else $error("select while idle");
  a_gap_level: assert property (
    busy_out && ser_out.cs_n && $past(ser_out.cs_n) |-> ser_out.sclk == cpol_r)
    else $error("sclk not at idle level");
endmodule
bind ssm_top ssm_properties u_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .apb_in(apb_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .miso_in(miso_in), .ser_out(ser_out), .busy_out(busy_out));

// ---- tb/tb_segment_spi_master.sv ----
// self-checking bench: apb master tasks, slave model, queue based expectations
// assumes the top module with a 16 word memory and a 100 mhz clock
`timescale 1ns/1ps
module tb_segment_spi_master;
  import ssm_pkg::*;
  logic clk, rst_n, pready, pslverr, miso, busy, cpol, done, e;
  logic [31:0] prdata, q;
  logic [15:0] slave_tx, rx_word;
  logic [4:0] rx_bits;
  ssm_apb_req_t req;
  ssm_serial_t ser;
  int bad_count, checked, w, n, seed;
  int wl[3] = '{1, 9, 16};
  logic [15:0] seen[$], exp[$], rx_q[$];
  logic [4:0] seen_bits[$];
  ssm_top #(.DEPTH(16), .AW(4)) dut (.clk_in(clk), .reset_n_in(rst_n), .apb_in(req),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .miso_in(miso),
    .ser_out(ser), .busy_out(busy));
  ssm_slave_model slave (.sclk_in(ser.sclk), .mosi_in(ser.mosi), .cs_n_in(ser.cs_n),
    .miso_out(miso), .cpol_in(cpol), .tx_word_in(slave_tx), .rx_word_out(rx_word),
    .rx_bits_out(rx_bits), .done_out(done));
  always #5 clk = ~clk;
  always @(done) begin
    seen.push_back(rx_word);
    seen_bits.push_back(rx_bits);
    rx_q.push_back(slave_tx);
    slave_tx = 16'($random(seed));
  end
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
    int k;
    k = 0;
    req.paddr <= a;
    req.pwrite <= wr;
    req.pwdata <= d;
    req.psel <= 1'b1;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    check("pready", 32'h1, 32'(pready));
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, q, e);
  endtask
  task automatic setup(input logic [1:0] md, input logic cp, input logic se);
    wr(SSM_CMD_OFS, 32'h4);
    wr(SSM_CTRL_OFS, {24'h0, 4'(w - 1), se, cp, md});
    cpol = cp;
    seen.delete();
    seen_bits.delete();
    rx_q.delete();
    exp.delete();
  endtask
  task automatic push(input logic [15:0] d);
    wr(SSM_TXDATA_OFS, {16'h0, d});
    exp.push_back(d);
  endtask
  task automatic wait_words(input int c);
    repeat (8000) if (seen.size() < c) @(posedge clk);
    check("word_count", 32'(c), 32'((seen.size() < c) ? seen.size() : c));
  endtask
  task automatic idle();
    repeat (3000) if (busy !== 1'b0) @(posedge clk);
    check("busy_end", 32'h0, 32'(busy));
  endtask
  task automatic cmp_tx(input int i);
    check("mosi_word", 32'(exp[i % exp.size()] >> (16 - w)), 32'(seen[i]));
    check("bit_count", 32'(w), 32'(seen_bits[i]));
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    seed = 32'h5072;
    clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    cpol = 1'b0;
    slave_tx = 16'h5a5a;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(SSM_DIV_OFS, 1'b0, 32'h0, q, e);
    check("div_reset", {16'h0000, DIV_RST}, q);
    apb(12'h080, 1'b0, 32'h0, q, e);
    check("unmapped_err", 32'h1, 32'(e));
    wr(SSM_DIV_OFS, 32'h3);
    wr(SSM_RATE_OFS, 32'd200);
    foreach (wl[k]) begin
      w = wl[k];
      setup(SSM_MODE_WORD, k[0], 1'b0);
      push(16'($random(seed)));
      wr(SSM_CMD_OFS, 32'h1);
      wait_words(1);
      repeat (400) @(posedge clk);
      idle();
      check("word_total", 32'h1, 32'(seen.size()));
      cmp_tx(0);
      apb(SSM_RXDATA_OFS, 1'b0, 32'h0, q, e);
      check("miso_word", 32'(rx_q[0] >> (16 - w)), q);
    end
    w = 12;
    setup(SSM_MODE_SEG, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) push(16'($random(seed)));
    wr(SSM_CMD_OFS, 32'h1);
    wait_words(1);
    push(16'h5555);
    wait_words(5);
    idle();
    repeat (400) @(posedge clk);
    check("seg_total", 32'h5, 32'(seen.size()));
    for (int i = 0; i < 5; i++) begin
      cmp_tx(i);
      apb(SSM_RXDATA_OFS, 1'b0, 32'h0, q, e);
      check("rx_fifo", 32'(rx_q[i] >> (16 - w)), q);
    end
    apb(SSM_STAT_OFS, 1'b0, 32'h0, q, e);
    check("rx_empty", 32'h1, 32'(q[1]));
    w = 8;
    setup(SSM_MODE_SEG, 1'b0, 1'b0);
    push(16'ha5c3);
    wr(SSM_CMD_OFS, 32'h1);
    wait_words(3);
    n = seen.size();
    push(16'h3c5a);
    wait_words(n + 3);
    for (int i = 0; i < n; i++) check("hold_last", 32'h00a5, 32'(seen[i]));
    check("new_word", 32'h003c, 32'(seen[n + 2]));
    wr(SSM_CMD_OFS, 32'h2);
    idle();
    w = 16;
    setup(SSM_MODE_CYC, 1'b1, 1'b0);
    for (int i = 0; i < 3; i++) push(16'($random(seed)));
    wr(SSM_CMD_OFS, 32'h1);
    // no append while the cycle runs
    wait_words(20);
    wr(SSM_CMD_OFS, 32'h2);
    idle();
    for (int i = 0; i < 20; i++) cmp_tx(i);
    apb(SSM_STAT_OFS, 1'b0, 32'h0, q, e);
    check("ovf_full", 32'h3, 32'(q[3:2]));
    apb(SSM_RXDATA_OFS, 1'b0, 32'h0, q, e);
    check("rx_oldest", 32'(rx_q[0]), q);
    wr(SSM_CMD_OFS, 32'h8);
    apb(SSM_STAT_OFS, 1'b0, 32'h0, q, e);
    check("ovf_clear", 32'h0, 32'(q[3]));
    wrap_up();
  end
endmodule
